// >>> logic/qdr_readback.sv
// Purpose: target side of the two-wire readback path of a quad DAC
// Assumes: SCL/SDA are open-drain pins sampled by clk; AXI4-Lite regs
// Notes: write data bytes are not served here; channel registers are
//   loaded over the register bus
//
// Contract
// [R1] controller starts, sends write address
// [R2] matching address is acknowledged by pulling low
// [R3] control byte received and acknowledged
// [R4] controller repeats start, sends read address
// [R5] read address acknowledged, device shifts MSB first
// [R6] selected channel comes from control byte
// [R7] flag clear: high byte then low byte
// [R8] flag set: power-down, high, low bytes
// [R9] high byte holds code bits eleven..four
// [R10] low byte holds code bits three..zero
// [R11] power-down byte: mode bits, six ones
// [R12] controller acknowledges all but last byte
// [R13] controller ends with stop or restart
// [R14] controller prefers restart to keep bus
// [R15] high-speed master code sent first
// [R16] master code is never acknowledged
// [R17] high-speed entry then same sequence follows
// [R18] stored mode bits encode output termination
// [R19] channel registers clear to zero at reset
// [R20] after final not-acknowledge release line, idle

`timescale 1ns/1ps

module qdr_readback
  import qdr_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // two-wire link pins
  input logic sclIn,
  input logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  // address straps
  input logic addrPinBitHi,
  input logic addrPinBitLo,
  // register bus
  input qdr_axi_in_type axiIn,
  output qdr_axi_out_type axiOut
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sclPrev;
    logic sdaPrev;
    qdr_phase_type phase;
    logic isAddr;
    logic readDir;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic [1:0] byteIdx;
    logic masterAck;
    qdr_ctrl_type ctrl;
    logic [7:0] readCount;
    logic sdaOeN;
    logic sdaOut;
    logic awHeld;
    qdr_regaddr_type awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    qdr_axi_out_type axo;
  } qdr_state_type;

  qdr_state_type st_r;
  qdr_state_type st_nxt;

  logic [QDR_SYN_W-1:0] synIn;
  logic [QDR_SYN_W-1:0] syn;
  qdr_entry_type [QDR_CHANNELS-1:0] entries;
  qdr_bank_wr_type bankWr;

  // ----------------------------------------------------------------
  // pin synchroniser and channel storage
  // ----------------------------------------------------------------
  assign synIn = {addrPinBitLo, addrPinBitHi, sdaIn, sclIn};

  qdr_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(synIn),
    .dout(syn)
  );

  qdr_chan_bank u_bank (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr(bankWr),
    .entries(entries)
  );

  // ----------------------------------------------------------------
  // readback byte builder
  // ----------------------------------------------------------------
  // the low nibble of the low byte is free; zero keeps it predictable
  function automatic logic [7:0] pickByte(input logic [1:0] idx,
                                          input qdr_entry_type e);
    logic [7:0] b;
    b = {e.codeLo, QDR_LOW_FILL}; // R10
    if (idx == QDR_IDX_PD) begin
      b = {e.pwrdnModeBitA, e.pwrdnModeBitB, QDR_PD_FILL}; // R11 R18
    end else if (idx == QDR_IDX_HI) begin
      b = e.codeHi; // R9
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic sclNow;
  logic sdaNow;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic [6:0] ownAddr;
  qdr_entry_type selEntry;
  logic [7:0] nextByte;
  logic [1:0] nextIdx;
  logic [31:0] oldWord;
  logic [31:0] newWord;
  qdr_status_type statusWord;

  always_comb begin
    st_nxt = st_r;
    bankWr = '0;
    sclNow = syn[QDR_SYN_SCL];
    sdaNow = syn[QDR_SYN_SDA];
    sclRise = sclNow && !st_r.sclPrev;
    sclFall = !sclNow && st_r.sclPrev;
    // data moving while the clock is high marks start or stop
    startCond = sclNow && st_r.sclPrev && st_r.sdaPrev && !sdaNow;
    stopCond = sclNow && st_r.sclPrev && !st_r.sdaPrev && sdaNow;
    ownAddr = {QDR_ADDR_PREFIX, syn[QDR_SYN_AHI], syn[QDR_SYN_ALO]};
    selEntry = entries[st_r.ctrl.chanSel]; // R6
    nextIdx = st_r.byteIdx + 2'h1;
    nextByte = pickByte(nextIdx, selEntry);
    oldWord = '0;
    newWord = '0;
    statusWord = '0;

    st_nxt.sclPrev = sclNow;
    st_nxt.sdaPrev = sdaNow;

    // link engine: a start anywhere restarts address reception,
    // which also covers the restart after the master code
    if (startCond) begin
      st_nxt.phase = QDR_RECV; // R4 R17
      st_nxt.isAddr = 1'b1;
      st_nxt.bitCnt = '0;
      st_nxt.sdaOeN = 1'b1;
    end else if (stopCond) begin
      st_nxt.phase = QDR_IDLE;
      st_nxt.sdaOeN = 1'b1;
    end else begin
      unique case (st_r.phase)
        QDR_IDLE: begin
          st_nxt.sdaOeN = 1'b1;
        end
        QDR_RECV: begin
          if (sclRise) begin
            st_nxt.shift = {st_r.shift[6:0], sdaNow};
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
          end
          if (sclFall && st_r.bitCnt == QDR_BYTE_BITS) begin
            st_nxt.bitCnt = '0;
            if (st_r.isAddr) begin
              // the master code never equals our address, so its
              // acknowledge slot is left released
              if (st_r.shift[7:1] == ownAddr) begin // R16
                st_nxt.readDir = st_r.shift[0];
                st_nxt.phase = QDR_ACK;
                st_nxt.sdaOeN = 1'b0; // R2 R5
              end else begin
                st_nxt.phase = QDR_IDLE;
              end
            end else begin
              st_nxt.ctrl = qdr_ctrl_type'(st_r.shift); // R3
              st_nxt.phase = QDR_ACK;
              st_nxt.sdaOeN = 1'b0; // R3
            end
          end
        end
        QDR_ACK: begin
          if (sclFall) begin
            st_nxt.sdaOeN = 1'b1;
            st_nxt.bitCnt = '0;
            if (st_r.readDir) begin
              // first byte depends on the power-down flag
              if (st_r.ctrl.powerDownFlag) begin
                st_nxt.byteIdx = QDR_IDX_PD; // R8
              end else begin
                st_nxt.byteIdx = QDR_IDX_HI; // R7
              end
              st_nxt.shift = pickByte(st_nxt.byteIdx, selEntry);
              st_nxt.sdaOeN = st_nxt.shift[7]; // R5
              st_nxt.phase = QDR_SEND;
            end else if (st_r.isAddr) begin
              st_nxt.isAddr = 1'b0;
              st_nxt.phase = QDR_RECV;
            end else begin
              // data bytes of a write belong to the write path
              st_nxt.phase = QDR_IDLE;
            end
          end
        end
        QDR_SEND: begin
          if (sclFall) begin
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
            if (st_r.bitCnt == QDR_LAST_BIT) begin
              st_nxt.sdaOeN = 1'b1;
              st_nxt.bitCnt = '0;
              st_nxt.phase = QDR_GETACK;
            end else begin
              st_nxt.shift = {st_r.shift[6:0], 1'b0};
              st_nxt.sdaOeN = st_r.shift[6]; // R5
            end
          end
        end
        QDR_GETACK: begin
          if (sclRise) begin
            st_nxt.masterAck = !sdaNow;
          end
          if (sclFall) begin
            if (st_r.masterAck && st_r.byteIdx != QDR_IDX_LO) begin
              st_nxt.byteIdx = nextIdx; // R7 R8
              st_nxt.shift = nextByte;
              st_nxt.sdaOeN = nextByte[7];
              st_nxt.phase = QDR_SEND;
            end else begin
              // end of read: line stays released until next start
              st_nxt.phase = QDR_IDLE; // R20
              if (st_r.byteIdx == QDR_IDX_LO) begin
                st_nxt.readCount = st_r.readCount + 8'h1;
              end
            end
          end
        end
      endcase
    end
    // open drain: only ever pull low
    st_nxt.sdaOut = 1'b0;

    // register bus: write address and data held until both arrive
    if (axiIn.awvalid && st_r.axo.awready) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = axiIn.awaddr;
    end
    if (axiIn.wvalid && st_r.axo.wready) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = axiIn.wdata;
      st_nxt.wStrb = axiIn.wstrb;
    end
    if (st_r.axo.bvalid && axiIn.bready) begin
      st_nxt.axo.bvalid = 1'b0;
    end
    if (st_r.awHeld && st_r.wHeld && !st_r.axo.bvalid) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.axo.bvalid = 1'b1;
      st_nxt.axo.bresp = QDR_RESP_DECERR;
      if (st_r.awAddr.page == QDR_PAGE_CHAN &&
          st_r.awAddr.lane == 2'h0) begin
        // byte enables merge into the stored entry
        oldWord = 32'(entries[st_r.awAddr.idx]);
        for (int b = 0; b < 4; b++) begin
          newWord[8*b +: 8] = st_r.wStrb[b] ?
            st_r.wData[8*b +: 8] : oldWord[8*b +: 8];
        end
        bankWr.en = 1'b1;
        bankWr.idx = st_r.awAddr.idx;
        bankWr.data = qdr_entry_type'(newWord[13:0]);
        st_nxt.axo.bresp = QDR_RESP_OKAY;
      end else if (st_r.awAddr == QDR_OFS_STATUS) begin
        // status is read-only; the write is accepted and dropped
        st_nxt.axo.bresp = QDR_RESP_OKAY;
      end
    end
    st_nxt.axo.awready = !st_nxt.awHeld;
    st_nxt.axo.wready = !st_nxt.wHeld;

    // register bus: read answers one cycle after the address
    if (st_r.axo.rvalid && axiIn.rready) begin
      st_nxt.axo.rvalid = 1'b0;
    end
    if (axiIn.arvalid && st_r.axo.arready) begin
      st_nxt.axo.rvalid = 1'b1;
      st_nxt.axo.rdata = '0;
      st_nxt.axo.rresp = QDR_RESP_DECERR;
      statusWord.readCount = st_r.readCount;
      statusWord.busy = (st_r.phase != QDR_IDLE);
      statusWord.ctrl = st_r.ctrl;
      if (axiIn.araddr == QDR_OFS_STATUS) begin
        st_nxt.axo.rdata = statusWord;
        st_nxt.axo.rresp = QDR_RESP_OKAY;
      end else if (axiIn.araddr.page == QDR_PAGE_CHAN &&
                   axiIn.araddr.lane == 2'h0) begin
        st_nxt.axo.rdata = 32'(entries[axiIn.araddr.idx]);
        st_nxt.axo.rresp = QDR_RESP_OKAY;
      end
    end
    st_nxt.axo.arready = !st_nxt.axo.rvalid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // released line and bus-idle samples keep reset from looking
  // like a start condition
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.sclPrev <= 1'b1;
      st_r.sdaPrev <= 1'b1;
      st_r.phase <= QDR_IDLE;
      st_r.sdaOeN <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sdaOut = st_r.sdaOut;
  assign sdaOeN = st_r.sdaOeN;
  assign axiOut = st_r.axo;

endmodule

// >>> logic/qdr_pkg.sv
// Purpose: shared constants and carrier types of the readback block
// Assumes: 200 MHz clk, register bus is AXI4-Lite with 8-bit addresses
// Notes: all field layouts live here as packed structs

package qdr_pkg;

  // ----------------------------------------------------------------
  // two-wire link constants
  // ----------------------------------------------------------------
  localparam logic [4:0] QDR_ADDR_PREFIX = 5'h13;
  localparam logic [3:0] QDR_BYTE_BITS = 4'h8;
  localparam logic [3:0] QDR_LAST_BIT = 4'h7;
  localparam logic [5:0] QDR_PD_FILL = 6'h3f;
  localparam logic [3:0] QDR_LOW_FILL = 4'h0;
  localparam logic [1:0] QDR_IDX_PD = 2'h0;
  localparam logic [1:0] QDR_IDX_HI = 2'h1;
  localparam logic [1:0] QDR_IDX_LO = 2'h2;
  localparam int QDR_CHANNELS = 4;

  // synchroniser lanes
  localparam int QDR_SYN_W = 4;
  localparam int QDR_SYN_SCL = 0;
  localparam int QDR_SYN_SDA = 1;
  localparam int QDR_SYN_AHI = 2;
  localparam int QDR_SYN_ALO = 3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] QDR_PAGE_STATUS = 4'h0;
  localparam logic [3:0] QDR_PAGE_CHAN = 4'h1;
  localparam logic [7:0] QDR_OFS_STATUS = {QDR_PAGE_STATUS, 4'h0};
  localparam logic [7:0] QDR_OFS_CHAN0 = {QDR_PAGE_CHAN, 4'h0};
  localparam logic [1:0] QDR_RESP_OKAY = 2'h0;
  localparam logic [1:0] QDR_RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pwrdnModeBitA;
    logic pwrdnModeBitB;
    logic [7:0] codeHi;
    logic [3:0] codeLo;
  } qdr_entry_type;

  typedef struct packed {
    logic [1:0] zeros;
    logic [1:0] updMode;
    logic spare;
    logic [1:0] chanSel;
    logic powerDownFlag;
  } qdr_ctrl_type;

  typedef struct packed {
    logic [7:0] pad;
    logic [7:0] readCount;
    logic [6:0] pad2;
    logic busy;
    qdr_ctrl_type ctrl;
  } qdr_status_type;

  typedef struct packed {
    logic [3:0] page;
    logic [1:0] idx;
    logic [1:0] lane;
  } qdr_regaddr_type;

  typedef struct packed {
    logic en;
    logic [1:0] idx;
    qdr_entry_type data;
  } qdr_bank_wr_type;

  typedef struct packed {
    logic awvalid;
    qdr_regaddr_type awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    qdr_regaddr_type araddr;
    logic rready;
  } qdr_axi_in_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } qdr_axi_out_type;

  typedef enum logic [2:0] {
    QDR_IDLE = 3'h0,
    QDR_RECV = 3'h1,
    QDR_ACK = 3'h3,
    QDR_SEND = 3'h2,
    QDR_GETACK = 3'h6
  } qdr_phase_type;

endpackage

// >>> logic/qdr_sync.sv
// Purpose: two-stage synchroniser for the link pins and address straps
// Assumes: inputs are asynchronous to clk
// Notes: only the second stage leaves this module

`timescale 1ns/1ps

module qdr_sync
  import qdr_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // raw and synchronised levels
  input logic [QDR_SYN_W-1:0] din,
  output logic [QDR_SYN_W-1:0] dout
);

  typedef struct packed {
    logic [QDR_SYN_W-1:0] stage1;
    logic [QDR_SYN_W-1:0] stage2;
  } qdr_sync_state_type;

  qdr_sync_state_type st_r;
  qdr_sync_state_type st_nxt;

  // ----------------------------------------------------------------
  // two flops, the first read only by the second
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt.stage1 = din;
    st_nxt.stage2 = st_r.stage1;
  end

  // idle bus level is high, so reset to ones avoids a false start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.stage2;

endmodule

// >>> logic/qdr_chan_bank.sv
// Purpose: four channel registers, power-down mode plus 12-bit code
// Assumes: one write port, all entries visible at once
// Notes: cleared at reset so readback shows zero until written

`timescale 1ns/1ps

module qdr_chan_bank
  import qdr_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // write port
  input qdr_bank_wr_type wr,
  // stored entries
  output qdr_entry_type [QDR_CHANNELS-1:0] entries
);

  typedef struct packed {
    qdr_entry_type [QDR_CHANNELS-1:0] ent;
  } qdr_bank_state_type;

  qdr_bank_state_type st_r;
  qdr_bank_state_type st_nxt;

  // ----------------------------------------------------------------
  // indexed write
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (wr.en) begin
      st_nxt.ent[wr.idx] = wr.data;
    end
  end

  // power-up value is zero in every entry
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0; // R19
    end else begin
      st_r <= st_nxt;
    end
  end

  assign entries = st_r.ent;

endmodule

// >>> test/qdr_readback_monitor.sv
// Purpose: concurrent checks on the ports of the readback block
// Assumes: link pins open-drain, bus clock phases far above 12 clk
// Notes: bound into every qdr_readback instance below
`timescale 1ns/1ps

module qdr_readback_monitor
  import qdr_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic sys_rst,
  // link pins and straps
  input logic sclIn,
  input logic sdaIn,
  input logic sdaOut,
  input logic sdaOeN,
  input logic addrPinBitHi,
  input logic addrPinBitLo,
  // register bus
  input qdr_axi_in_type axiIn,
  input qdr_axi_out_type axiOut
);
  // ----------------------------------------------------------------
  // helper: cycles since the bus clock last moved
  // ----------------------------------------------------------------
  logic sclPrev_r;
  logic [7:0] stillCnt_r;

  // saturates so a stuck clock cannot wrap back under the bound
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclPrev_r <= 1'b1;
      stillCnt_r <= 8'h00;
    end else begin
      sclPrev_r <= sclIn;
      if (sclIn != sclPrev_r) stillCnt_r <= 8'h00;
      else if (stillCnt_r != 8'hff) stillCnt_r <= stillCnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence wr_take;
    axiIn.awvalid && axiOut.awready && axiIn.wvalid && axiOut.wready;
  endsequence
  sequence rd_take;
    axiIn.arvalid && axiOut.arready;
  endsequence

  rst_quiet_a: assert property (disable iff (1'b0)
    sys_rst |-> sdaOeN && !axiOut.bvalid && !axiOut.rvalid)
    else $error("outputs active during reset");
  pull_low_a: assert property (!sdaOeN |-> !sdaOut)
    else $error("data pin driven high");
  sda_steady_a: assert property ($changed(sdaOeN) |-> !sclIn)
    else $error("data line moved while bus clock high");
  sda_release_a: assert property (!sdaOeN |-> stillCnt_r < 8'h28)
    else $error("data line held with bus clock still");
  wr_answer_a: assert property (wr_take |=> !axiOut.bvalid ##1 axiOut.bvalid)
    else $error("write response not two cycles after take");
  wr_clear_a: assert property (axiOut.bvalid && axiIn.bready |=> !axiOut.bvalid)
    else $error("write response not cleared");
  rd_answer_a: assert property (rd_take |=> axiOut.rvalid && !axiOut.arready)
    else $error("read data not one cycle after take");
  rd_clear_a: assert property (axiOut.rvalid && axiIn.rready |=> !axiOut.rvalid)
    else $error("read data not cleared");
  decerr_zero_a: assert property (
    axiOut.rvalid && axiOut.rresp == QDR_RESP_DECERR |-> axiOut.rdata == 32'h0)
    else $error("refused read returned data");
endmodule

bind qdr_readback qdr_readback_monitor mon (.clk(clk), .sys_rst(sys_rst),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
  .addrPinBitHi(addrPinBitHi), .addrPinBitLo(addrPinBitLo),
  .axiIn(axiIn), .axiOut(axiOut));

// >>> test/qdr_i2c_master.sv
// Purpose: two-wire bus controller model, master receiver side
// Assumes: 160 ns bus clock, four 40 ns quarters per bit, clk 5 ns
// Notes: bus clock stands high after a stop, low between restarted frames; data released = pulled up
`timescale 1ns/1ps

module qdr_i2c_master (
  // clock
  input logic clk,
  // data line level on the wire
  input logic sda,
  // bus clock level and data pull-down enable
  output logic scl,
  output logic sdaOeN
);
  // ----------------------------------------------------------------
  // bus primitives
  // ----------------------------------------------------------------
  // idle bus at time zero
  initial begin
    scl = 1'b1;
    sdaOeN = 1'b1;
  end

  // one quarter of a bit period
  task automatic quarter();
    repeat (8) @(posedge clk);
  endtask

  // start or repeated start: data falls with the clock high
  task automatic start();
    sdaOeN <= 1'b1;
    quarter();
    scl <= 1'b1;
    quarter();
    sdaOeN <= 1'b0;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask

  // stop: data rises with the clock high
  task automatic stop();
    sdaOeN <= 1'b0;
    quarter();
    scl <= 1'b1;
    quarter();
    sdaOeN <= 1'b1;
    quarter();
  endtask

  // data set while the clock is low, wire sampled mid-high
  task automatic bitSlot(input logic tx, output logic rx);
    sdaOeN <= tx;
    quarter();
    scl <= 1'b1;
    quarter();
    rx = sda;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask

  // eight bits msb first, then the acknowledge slot
  task automatic byteIo(input logic [7:0] tx, input logic ackTx,
                        output logic [7:0] rx, output logic ackRx);
    for (int i = 7; i >= 0; i--) bitSlot(tx[i], rx[i]);
    bitSlot(ackTx, ackRx);
  endtask
endmodule

// >>> test/qdr_readback_bench.sv
// Purpose: self-checking bench of the two-wire readback block
// Assumes: channels loaded over the register bus, straps set per test
// Notes: expected bytes worked out by hand from the stored entries
`timescale 1ns/1ps

module qdr_readback_bench
  import qdr_pkg::*;
  ;
  // ----------------------------------------------------------------
  // signals, instances, tasks
  // ----------------------------------------------------------------
  logic clk;
  logic sys_rst;
  logic scl;
  logic mOeN;
  logic sda;
  logic sdaOeN;
  logic sdaOut;
  logic hiPin;
  logic loPin;
  qdr_axi_in_type axiIn;
  qdr_axi_out_type axiOut;
  int fail_count;
  int checks_done;
  logic [7:0] rx;
  logic ack;
  logic [31:0] rd;
  logic [1:0] resp;
  logic [7:0] ctlTab [5] = '{8'h02, 8'h03, 8'h05, 8'h36, 8'h01};
  logic [23:0] expTab [5] = '{24'h00abc0, 24'hbfabc0, 24'h7f0050,
                              24'h00fe70, 24'h3f0000};

  // wire with pull-up: low while either side pulls it
  assign sda = sdaOeN & mOeN;

  qdr_readback dut (.clk(clk), .sys_rst(sys_rst), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .addrPinBitHi(hiPin),
    .addrPinBitLo(loPin), .axiIn(axiIn), .axiOut(axiOut));
  qdr_i2c_master host (.clk(clk), .sda(sda), .scl(scl), .sdaOeN(mOeN));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // case equality so an unknown never matches
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // address and data offered together, each released once taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
    @(posedge clk);
    axiIn.awvalid <= 1'b1;
    axiIn.awaddr <= a;
    axiIn.wvalid <= 1'b1;
    axiIn.wdata <= d;
    axiIn.wstrb <= 4'hf;
    axiIn.bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (axiOut.awready) axiIn.awvalid <= 1'b0;
      if (axiOut.wready) axiIn.wvalid <= 1'b0;
      if (axiOut.bvalid) begin
        r = axiOut.bresp;
        axiIn.bready <= 1'b0;
        return;
      end
    end
    check("write response", 32'h1, 32'h0);
    end_sim();
  endtask

  // read; rready held until the data is seen
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    @(posedge clk);
    axiIn.arvalid <= 1'b1;
    axiIn.araddr <= a;
    axiIn.rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (axiOut.arready) axiIn.arvalid <= 1'b0;
      if (axiOut.rvalid) begin
        d = axiOut.rdata;
        r = axiOut.rresp;
        axiIn.rready <= 1'b0;
        return;
      end
    end
    check("read response", 32'h1, 32'h0);
    end_sim();
  endtask

  // full readback frame, optionally behind the high-speed master code
  task automatic readback(input logic [7:0] ctrl, input logic hs,
                          input logic [1:0] pins, input logic [23:0] exp);
    logic [7:0] a;
    int n;
    a = {QDR_ADDR_PREFIX, pins, 1'b0};
    n = ctrl[0] ? 3 : 2;
    if (hs) begin
      host.start();
      host.byteIo(8'h08, 1'b1, rx, ack);
      check("master code ack", 32'h1, ack);
    end
    host.start();
    host.byteIo(a, 1'b1, rx, ack);
    check("write address ack", 32'h0, ack);
    host.byteIo(ctrl, 1'b1, rx, ack);
    check("control ack", 32'h0, ack);
    host.start();
    host.byteIo(a | 8'h01, 1'b1, rx, ack);
    check("read address ack", 32'h0, ack);
    for (int i = 0; i < n; i++) begin
      host.byteIo(8'hff, i == n - 1, rx, ack);
      check("readback byte",
            exp[8*(n-1-i) +: 8], rx);
    end
    // flag-set frames keep the bus and restart into the next frame
    if (!ctrl[0]) host.stop();
    check("line released", 32'h1, sdaOeN);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    // scheduled so the reset edge reaches processes still starting up
    sys_rst <= 1'b1;
    axiIn = '0;
    hiPin = 1'b0;
    loPin = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    // cleared channels, refused addresses
    for (logic [7:0] a = QDR_OFS_CHAN0; a < 8'h20; a += 8'h04) begin
      axiRead(a, rd, resp);
      check("channel reset value", 32'h0, rd);
    end
    axiRead(8'h20, rd, resp);
    check("unmapped read resp", 32'h3, resp);
    check("unmapped read data", 32'h0, rd);
    axiRead(8'h11, rd, resp);
    check("misaligned read resp", 32'h3, resp);
    axiWrite(8'h24, 32'h0000ffff, resp);
    check("unmapped write resp", 32'h3, resp);
    $display("test reset and map done");
    // channel entries: mode bits a,b then 12-bit code
    axiWrite(QDR_OFS_CHAN0 + 8'h04, 32'h00002abc, resp);
    axiWrite(QDR_OFS_CHAN0 + 8'h08, 32'h00001005, resp);
    axiWrite(QDR_OFS_CHAN0 + 8'h0c, 32'h00003fe7, resp);
    check("channel write resp", 32'h0, resp);
    axiRead(QDR_OFS_CHAN0 + 8'h0c, rd, resp);
    check("channel stored", 32'h00003fe7, rd);
    $display("test channel load done");
    // every strap value, both byte counts, one high-speed entry
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      hiPin <= i[1];
      loPin <= i[0];
      repeat (4) @(posedge clk);
      readback(ctlTab[i], i == 2, i[1:0], expTab[i]);
    end
    $display("test readback frames done");
    // straps at zero, address for straps three must be ignored
    host.start();
    host.byteIo({QDR_ADDR_PREFIX, 2'h3, 1'b0}, 1'b1, rx, ack);
    check("foreign address ack", 32'h1, ack);
    host.stop();
    axiWrite(QDR_OFS_STATUS, 32'hffffffff, resp);
    check("status write resp", 32'h0, resp);
    axiRead(QDR_OFS_STATUS, rd, resp);
    check("status count and control", 32'h00050001, rd);
    $display("test address filter and status done");
    end_sim();
  end
endmodule
